// ### rtl/ics_pkg.sv
// Operation
// - After a start, the top four control-byte bits are compared with the programmed control code.
// - The next three bits are the block select and the last bit is the direction, one for read.
// - A control byte that addresses the device is acknowledged at once, unless a reload is running.
// - The byte pointer is the block select bits joined above the eight-bit word address.
// - In a byte write the master sends one data byte after the address and the device acks it.
// - The received data byte is committed when the device drives its acknowledge.
// - A repeated start abandons write decoding but keeps the loaded pointer.
// - A read-direction control byte is acknowledged and then the addressed byte is shifted out.
// - Block 000 reaches the working registers, which are restored from the stored image on reload.
// - Block 010 reaches the non-volatile configuration store so it can be reprogrammed.
package ics_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  // Data out hold after clock low, in ns
  localparam int T_DH_NS = 50;
  localparam int HOLD_CYC = (T_DH_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Control byte and address map
  // ****************************************
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;
  localparam int BLK_MSB = 3;
  localparam int BLK_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int BIT_CNT_FULL = 8;
  localparam int TX_LAST = 7;
  localparam logic [2:0] BLK_REGS = 3'h0;
  localparam logic [2:0] BLK_NVM = 3'h2;
  localparam logic [7:0] CODE_ADDR = 8'hCA;
  localparam logic [3:0] CODE_RST = 4'hE;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam logic [7:0] IMG_RST = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ICS_IDLE,
    ICS_CTRL,
    ICS_ADDR,
    ICS_WDATA,
    ICS_ACK,
    ICS_TX,
    ICS_MACK
  } ics_state_t;

endpackage

// ### rtl/ics_if.sv
`timescale 1ns/1ps

// ****************************************
// Bus condition events
// ****************************************
interface ics_evt_if;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic sda;
  modport src (output rise, output fall, output start, output stop, output sda);
  modport dst (input rise, input fall, input start, input stop, input sda);
endinterface

// ****************************************
// Configuration space access
// ****************************************
interface ics_mem_if;
  logic [10:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  logic busy;
  logic [3:0] code;
  modport ctl (output addr, output wdata, output wr, input rdata, input busy, input code);
  modport store (input addr, input wdata, input wr, output rdata, output busy, output code);
endinterface

// ### rtl/ics_cond.sv
`timescale 1ns/1ps

module ics_cond (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic scl,
  input wire logic sda,
  ics_evt_if.src ev
);
  logic scl_q, sda_q, rise_q, fall_q, start_q, stop_q, smp_q;
  logic [7:0] hold_q;

  // Edge and condition capture, all registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rise_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      smp_q <= 1'b1;
    end else if (en) begin
      scl_q <= scl;
      sda_q <= sda;
      smp_q <= sda;
      rise_q <= scl & ~scl_q;
      start_q <= scl & scl_q & sda_q & ~sda;
      stop_q <= scl & scl_q & ~sda_q & sda;
    end
  end

  // Falling edge held back so data out keeps its hold time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 8'h00;
      fall_q <= 1'b0;
    end else if (en) begin
      fall_q <= (hold_q == 8'h01);
      if (~scl & scl_q) begin
        hold_q <= 8'(ics_pkg::HOLD_CYC);
      end else if (hold_q != 8'h00) begin
        hold_q <= hold_q - 8'h01;
      end
    end
  end

  assign ev.rise = rise_q;
  assign ev.fall = fall_q;
  assign ev.start = start_q;
  assign ev.stop = stop_q;
  assign ev.sda = smp_q;

endmodule // ics_cond

// ### rtl/ics_store.sv
`timescale 1ns/1ps

module ics_store (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic reload,
  input wire logic [7:0] look_addr,
  output logic [7:0] look_data,
  ics_mem_if.store m
);
  logic [7:0] work_q [256];
  logic [7:0] nvm_q [256];
  logic rl_busy_q;
  logic [7:0] rl_cnt_q;
  logic [2:0] blk;

  // Factory image: only the control code byte is non-zero
  function automatic logic [7:0] img(input logic [7:0] a);
    img = (a == ics_pkg::CODE_ADDR) ? {ics_pkg::CODE_RST, 4'h0} : ics_pkg::IMG_RST;
  endfunction

  assign blk = m.addr[10:8];

  // Reload walker copies the stored image into the working set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rl_busy_q <= 1'b0;
      rl_cnt_q <= 8'h00;
    end else if (en) begin
      if (reload && !rl_busy_q) begin
        rl_busy_q <= 1'b1;
        rl_cnt_q <= 8'h00;
      end else if (rl_busy_q) begin
        rl_cnt_q <= rl_cnt_q + 8'h01;
        rl_busy_q <= (rl_cnt_q != 8'hFF);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 256; i++) begin
        work_q[i] <= img(8'(i));
      end
    end else if (en) begin
      if (rl_busy_q) begin
        work_q[rl_cnt_q] <= nvm_q[rl_cnt_q];
      end else if (m.wr && blk == ics_pkg::BLK_REGS) begin
        work_q[m.addr[7:0]] <= m.wdata;
      end
    end
  end

  // non-volatile image, reset models first power-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 256; i++) begin
        nvm_q[i] <= img(8'(i));
      end
    end else if (en) begin
      if (m.wr && blk == ics_pkg::BLK_NVM && !rl_busy_q) begin
        nvm_q[m.addr[7:0]] <= m.wdata;
      end
    end
  end

  // Read side: unmapped blocks read a fixed value
  always_comb begin
    if (blk == ics_pkg::BLK_REGS) begin
      m.rdata = work_q[m.addr[7:0]];
    end else if (blk == ics_pkg::BLK_NVM) begin
      m.rdata = nvm_q[m.addr[7:0]];
    end else begin
      m.rdata = ics_pkg::UNMAPPED_RD;
    end
  end

  assign m.busy = rl_busy_q;
  assign m.code = work_q[ics_pkg::CODE_ADDR][ics_pkg::CODE_MSB:ics_pkg::CODE_LSB];
  assign look_data = work_q[look_addr];

endmodule // ics_store

// ### rtl/ics_top.sv
`timescale 1ns/1ps

module ics_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic cfg_reload,
  input wire logic [7:0] cfg_look_addr,
  output logic [7:0] cfg_look_data,
  output logic bus_active
);

  // ****************************************
  // Declarations
  // ****************************************
  ics_evt_if ev ();
  ics_mem_if mem ();

  ics_pkg::ics_state_t st_q;
  ics_pkg::ics_state_t nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [2:0] blk_q;
  logic [10:0] ptr_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic mack_ok_q;
  logic wr_q;
  logic [7:0] wdat_q;
  logic [7:0] look_q;
  logic active_q;
  logic [7:0] look_w;

  // Decision terms, valid in the cycle of a held-back fall
  logic byte_done;
  logic hit;
  logic is_read;
  logic tx_end;

  // ****************************************
  // Submodules
  // ****************************************
  ics_cond u_cond (
    .clk(clk),
    .arst_n(arst_n),
    .en(en),
    .scl(scl_in),
    .sda(sda_in),
    .ev(ev)
  );

  ics_store u_store (
    .clk(clk),
    .arst_n(arst_n),
    .en(en),
    .reload(cfg_reload),
    .look_addr(cfg_look_addr),
    .look_data(look_w),
    .m(mem)
  );

  // ****************************************
  // Helpers
  // ****************************************

  // Receiving states share one shifter and one decision point
  function automatic logic rx_state(input ics_pkg::ics_state_t s);
    rx_state = (s == ics_pkg::ICS_CTRL) || (s == ics_pkg::ICS_ADDR) ||
               (s == ics_pkg::ICS_WDATA);
  endfunction

  // Open-drain: driving low means enable high
  function automatic logic drive_low(input logic b);
    drive_low = ~b;
  endfunction

  always_comb begin
    byte_done = ev.fall && rx_state(st_q) && (cnt_q == 4'(ics_pkg::BIT_CNT_FULL));
    hit = (rx_q[ics_pkg::CODE_MSB:ics_pkg::CODE_LSB] == mem.code) && !mem.busy;
    is_read = rx_q[ics_pkg::RW_BIT];
    tx_end = ev.fall && (st_q == ics_pkg::ICS_TX) && (cnt_q == 4'(ics_pkg::TX_LAST));
  end

  // ****************************************
  // Receive shifter
  // ****************************************

  // Sample on rising clock while a byte is coming in
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q <= 8'h00;
    end else if (en) begin
      if (ev.rise && rx_state(st_q)) begin
        rx_q <= {rx_q[6:0], ev.sda};
      end
    end
  end

  // ****************************************
  // Transaction sequencer
  // ****************************************

  // Start and stop override everything, even mid-byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ics_pkg::ICS_IDLE;
      nxt_q <= ics_pkg::ICS_IDLE;
      cnt_q <= 4'h0;
      blk_q <= 3'h0;
      mack_ok_q <= 1'b0;
    end else if (en) begin
      if (ev.start) begin
        st_q <= ics_pkg::ICS_CTRL;
        cnt_q <= 4'h0;
      end else if (ev.stop) begin
        st_q <= ics_pkg::ICS_IDLE;
        cnt_q <= 4'h0;
      end else begin
        case (st_q)
          ics_pkg::ICS_CTRL: begin
            if (ev.rise) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (byte_done) begin
              if (hit) begin
                blk_q <= rx_q[ics_pkg::BLK_MSB:ics_pkg::BLK_LSB];
                st_q <= ics_pkg::ICS_ACK;
                nxt_q <= is_read ? ics_pkg::ICS_TX : ics_pkg::ICS_ADDR;
              end else begin
                st_q <= ics_pkg::ICS_IDLE;
              end
            end
          end
          ics_pkg::ICS_ADDR: begin
            if (ev.rise) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (byte_done) begin
              st_q <= ics_pkg::ICS_ACK;
              nxt_q <= ics_pkg::ICS_WDATA;
            end
          end
          ics_pkg::ICS_WDATA: begin
            if (ev.rise) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (byte_done) begin
              st_q <= ics_pkg::ICS_ACK;
              nxt_q <= ics_pkg::ICS_WDATA;
            end
          end
          ics_pkg::ICS_ACK: begin
            if (ev.fall) begin
              st_q <= nxt_q;
              cnt_q <= 4'h0;
            end
          end
          ics_pkg::ICS_TX: begin
            if (ev.fall) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (tx_end) begin
              st_q <= ics_pkg::ICS_MACK;
            end
          end
          ics_pkg::ICS_MACK: begin
            if (ev.rise) begin
              mack_ok_q <= ~ev.sda;
            end
            if (ev.fall) begin
              // Master NACK ends the read; wait for stop or start
              st_q <= mack_ok_q ? ics_pkg::ICS_TX : ics_pkg::ICS_IDLE;
              cnt_q <= 4'h0;
            end
          end
          default: begin
            cnt_q <= 4'h0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Byte pointer
  // ****************************************

  // Pointer survives repeated start so a random read can follow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= 11'h000;
    end else if (en) begin
      if (byte_done && st_q == ics_pkg::ICS_ADDR) begin
        ptr_q <= {blk_q, rx_q};
      end else if (byte_done && st_q == ics_pkg::ICS_CTRL && hit && is_read) begin
        // Current-address read keeps the word part
        ptr_q[10:8] <= rx_q[ics_pkg::BLK_MSB:ics_pkg::BLK_LSB];
      end else if (wr_q || tx_end) begin
        ptr_q[7:0] <= ptr_q[7:0] + 8'h01;
      end
    end
  end

  // ****************************************
  // Write commit
  // ****************************************

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      wdat_q <= 8'h00;
    end else if (en) begin
      wr_q <= byte_done && st_q == ics_pkg::ICS_WDATA;
      if (byte_done && st_q == ics_pkg::ICS_WDATA) begin
        wdat_q <= rx_q;
      end
    end
  end

  assign mem.addr = ptr_q;
  assign mem.wdata = wdat_q;
  assign mem.wr = wr_q;

  // ****************************************
  // Transmit shifter
  // ****************************************

  // Load from the store at the start of each read byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= 8'h00;
    end else if (en) begin
      if (ev.fall && st_q == ics_pkg::ICS_ACK && nxt_q == ics_pkg::ICS_TX) begin
        tx_q <= mem.rdata;
      end else if (ev.fall && st_q == ics_pkg::ICS_MACK && mack_ok_q) begin
        tx_q <= mem.rdata;
      end else if (ev.fall && st_q == ics_pkg::ICS_TX) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Data line drive
  // ****************************************

  // Changes follow the held-back fall, except the release on a start or stop; never a rising edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_q <= 1'b0;
    end else if (en) begin
      if (ev.start || ev.stop) begin
        sda_oe_q <= 1'b0;
      end else if (byte_done) begin
        sda_oe_q <= (st_q != ics_pkg::ICS_CTRL) || hit;
      end else if (ev.fall) begin
        case (st_q)
          ics_pkg::ICS_ACK: begin
            // first read bit after the ack
            sda_oe_q <= (nxt_q == ics_pkg::ICS_TX) ? drive_low(mem.rdata[7]) : 1'b0;
          end
          ics_pkg::ICS_TX: begin
            sda_oe_q <= tx_end ? 1'b0 : drive_low(tx_q[6]);
          end
          ics_pkg::ICS_MACK: begin
            sda_oe_q <= mack_ok_q ? drive_low(mem.rdata[7]) : 1'b0;
          end
          default: begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Status and lookup outputs
  // ****************************************

  // Registered copies keep every output on a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out_q <= 1'b0;
      look_q <= 8'h00;
      active_q <= 1'b0;
    end else if (en) begin
      sda_out_q <= 1'b0;
      look_q <= look_w;
      active_q <= (st_q != ics_pkg::ICS_IDLE);
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign cfg_look_data = look_q;
  assign bus_active = active_q;

endmodule // ics_top

// ### sim/ics_assertions.sv
`timescale 1ns/1ps
// ********
// Port checker for the I2C target
// ********
module ics_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic cfg_reload,
  input wire logic [7:0] cfg_look_addr,
  input wire logic [7:0] cfg_look_data,
  input wire logic bus_active
);
  logic [7:0] low_cnt_q;
  logic [9:0] rl_cnt_q;
  // Cycles with SCL low, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_q <= 8'h00;
    end else if (scl_in) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  // Cycles since reset or reload; the copy needs 256 of them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rl_cnt_q <= 10'h000;
    end else if (cfg_reload) begin
      rl_cnt_q <= 10'h000;
    end else if (rl_cnt_q != 10'h3FF) begin
      rl_cnt_q <= rl_cnt_q + 10'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Drive changes only in the hold slot after an SCL fall
  property p_oe_slot;
    $changed(sda_oe) |-> !scl_in && low_cnt_q >= 8'h0B && low_cnt_q <= 8'h0F;
  endproperty
  a_oe_slot: assert property (p_oe_slot) else $error("SDA drive moved off slot");
  // Ack or data bit stands while SCL is high
  property p_oe_steady;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_oe_steady: assert property (p_oe_steady) else $error("SDA drive moved in high");
  // Open drain: only ever pulls low
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("SDA driven high");
  // An idle target never drives the data line
  property p_idle_quiet;
    !bus_active [*2] |-> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Idle target drives SDA");
  // A start wakes the decoder
  property p_start_wakes;
    en && scl_in && $fell(sda_in) |-> ##[1:6] bus_active;
  endproperty
  a_start_wakes: assert property (p_start_wakes) else $error("Start not seen");
  // A stop ends the transaction
  property p_stop_idles;
    en && scl_in && $rose(sda_in) |-> ##[1:6] !bus_active ##1 !bus_active;
  endproperty
  a_stop_idles: assert property (p_stop_idles) else $error("Stop not seen");
  // Working registers change only by bus write or reload
  property p_look_steady;
    rl_cnt_q > 10'h12C && !bus_active && $stable(cfg_look_addr) |=> $stable(cfg_look_data);
  endproperty
  a_look_steady: assert property (p_look_steady) else $error("Register changed unasked");
  // Enable low freezes every output
  property p_en_freeze;
    !en |=> $stable(sda_oe) && $stable(bus_active) && $stable(cfg_look_data);
  endproperty
  a_en_freeze: assert property (p_en_freeze) else $error("Outputs moved while frozen");
endmodule // ics_assertions

bind ics_top ics_assertions u_chk (
  .clk(clk), .arst_n(arst_n), .en(en), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .cfg_reload(cfg_reload),
  .cfg_look_addr(cfg_look_addr), .cfg_look_data(cfg_look_data), .bus_active(bus_active)
);

// ### sim/ics_master.sv
`timescale 1ns/1ps
// ********
// I2C bus master model at minimum low and high times
// ********
module ics_master #(
  parameter int T_LOW = 260,
  parameter int T_HIGH = 120
) (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic m_sda
);
  // Released bus; pull-ups hold both lines high
  initial begin
    scl = 1'b1;
    m_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One clock pulse; short hold after the fall avoids a false start
  task automatic pulse(output logic s);
    w(T_LOW);
    scl = 1'b1;
    w(T_HIGH / 2);
    s = sda_w;
    w(T_HIGH / 2);
    scl = 1'b0;
    w(4);
  endtask
  task automatic bus_start();
    m_sda = 1'b1;
    w(T_LOW);
    scl = 1'b1;
    w(T_HIGH);
    m_sda = 1'b0;
    w(T_HIGH);
    scl = 1'b0;
    w(4);
  endtask
  task automatic bus_stop();
    m_sda = 1'b0;
    w(T_LOW);
    scl = 1'b1;
    w(T_HIGH);
    m_sda = 1'b1;
    w(T_LOW);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      m_sda = b[i];
      pulse(s);
    end
    m_sda = 1'b1;
    pulse(s);
    ack = ~s;
  endtask
  // Last byte of a read is refused to free the line
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    m_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      d[i] = s;
    end
    m_sda = last;
    pulse(s);
  endtask
endmodule // ics_master

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic en = 1'b1;
  logic cfg_reload = 1'b0;
  logic [7:0] cfg_look_addr = 8'h00;
  logic [7:0] cfg_look_data;
  logic scl, m_sda, sda_w, sda_out, sda_oe, bus_active;
  int n_mismatch = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  // Wire level: low while either side pulls
  assign sda_w = m_sda & ~(sda_oe & ~sda_out);
  ics_top u_dut (
    .clk(clk), .arst_n(arst_n), .en(en), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .cfg_reload(cfg_reload),
    .cfg_look_addr(cfg_look_addr), .cfg_look_data(cfg_look_data), .bus_active(bus_active)
  );
  ics_master u_mst (.clk(clk), .sda_w(sda_w), .scl(scl), .m_sda(m_sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_mst.wr_byte(b, a);
    chk({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic rd(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    u_mst.rd_byte(last, d);
    chk(d, exp);
  endtask
  // Look port is registered, so allow a settled cycle
  task automatic look(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) cfg_look_addr = a;
    repeat (2) @(negedge clk);
    chk(cfg_look_data, exp);
  endtask
  // Two bytes written back to back into the working registers
  task automatic t_write();
    u_mst.bus_start();
    wr(8'hE0, 1'b1);
    wr(8'h10, 1'b1);
    wr(8'hA5, 1'b1);
    wr(8'h3C, 1'b1);
    u_mst.bus_stop();
    look(8'h10, 8'hA5);
    look(8'h11, 8'h3C);
  endtask
  // Random read, then a current-address read from the advanced pointer
  task automatic t_read();
    u_mst.bus_start();
    wr(8'hE0, 1'b1);
    wr(8'h10, 1'b1);
    u_mst.bus_start();
    wr(8'hE1, 1'b1);
    rd(1'b1, 8'hA5);
    u_mst.bus_stop();
    u_mst.bus_start();
    wr(8'hE1, 1'b1);
    rd(1'b1, 8'h3C);
    u_mst.bus_stop();
  endtask
  // New code, page into the stored image, reload restores all, then a two-byte store read
  task automatic t_code();
    u_mst.bus_start();
    wr(8'hE0, 1'b1);
    wr(8'hCA, 1'b1);
    wr(8'h90, 1'b1);
    u_mst.bus_stop();
    u_mst.bus_start();
    wr(8'hE0, 1'b0);
    u_mst.bus_stop();
    u_mst.bus_start();
    wr(8'h94, 1'b1);
    wr(8'h20, 1'b1);
    wr(8'h5A, 1'b1);
    wr(8'h6B, 1'b1);
    u_mst.bus_stop();
    look(8'h20, 8'h00);
    @(negedge clk) cfg_reload = 1'b1;
    @(negedge clk) cfg_reload = 1'b0;
    repeat (300) @(negedge clk);
    look(8'h21, 8'h6B);
    look(8'h10, 8'h00);
    look(8'hCA, 8'hE0);
    u_mst.bus_start();
    wr(8'hE4, 1'b1);
    wr(8'h20, 1'b1);
    u_mst.bus_start();
    wr(8'hE5, 1'b1);
    // Master ack on the first byte keeps the read going
    rd(1'b0, 8'h5A);
    rd(1'b1, 8'h6B);
    u_mst.bus_stop();
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence; a short freeze first exercises the enable
  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    en = 1'b0;
    cfg_look_addr = 8'hCA;
    repeat (4) @(negedge clk);
    chk(cfg_look_data, 8'h00); // Frozen look port
    en = 1'b1;
    look(8'hCA, 8'hE0);
    t_write();
    t_read();
    t_code();
    end_sim();
  end
  // Watchdog about a tenth above the expected 89k cycles, kept under 100k
  initial begin
    #490000;
    n_mismatch++;
    end_sim();
  end
endmodule // tb_top
